//--- hdl/tbc_pin_filter.sv
/*
 three-flop synchroniser and glitch filter for one external pin.
 assumes an asynchronous pin; output changes once flops two and three agree.
*/
`timescale 1ns/1ps
module tbc_pin_filter (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PIN,
	output logic LEVEL,
	output logic FALL,
	output logic RISE
);
	logic [2:0] sync_q;
	logic level_q;
	logic prev_q;
	logic agree;

	// a pulse of one clock never shows equal in stages two and three
	assign agree = (sync_q[1] == sync_q[2]);

	always_ff @(posedge CLK) begin
		if (RST) begin
			sync_q <= 3'h7;
			level_q <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			sync_q <= {sync_q[1:0], PIN};
			if (agree) level_q <= sync_q[2];
			prev_q <= level_q;
		end
	end

	assign LEVEL = level_q;
	assign FALL = prev_q & ~level_q;
	assign RISE = ~prev_q & level_q;
endmodule // tbc_pin_filter

//--- hdl/tbc_pkg.sv
/*
 package for the timer base and control block: register map, field
 positions, reset values, timing counts and the shared types.
 assumes a 20 MHz system clock and a word-aligned AHB-Lite register bus.
*/
package tbc_pkg;
	////////////////////////////////////////////////////////////////////////
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int TIME_BASE_CYCLES = 2;
	localparam int T0O_DIVIDE = 64;
	localparam int T2O_DIVIDE = 2;
	localparam int T0O_HALF = T0O_DIVIDE / 2;
	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_TIMER0_LOW = 8'h8C;
	localparam logic [7:0] ADDR_TIMER0_HIGH = 8'h90;
	localparam logic [7:0] ADDR_TIMER1_LOW = 8'h94;
	localparam logic [7:0] ADDR_TIMER1_HIGH = 8'h98;
	localparam logic [7:0] ADDR_MODE_SELECT = 8'h9C;
	localparam logic [7:0] ADDR_PIN_CTRL = 8'hA0;
	localparam logic [7:0] ADDR_TIMER2_LOW = 8'hA4;
	localparam logic [7:0] ADDR_TIMER2_HIGH = 8'hA8;
	localparam logic [7:0] ADDR_TIMER3_COUNT = 8'hAC;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hB0;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'hB4;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hB8;
	////////////////////////////////////////////////////////////////////////
	localparam int TC_TF1 = 7;
	localparam int TC_TR1 = 6;
	localparam int TC_TF0 = 5;
	localparam int TC_TR0 = 4;
	localparam int TC_IE1 = 3;
	localparam int TC_IT1 = 2;
	localparam int TC_IE0 = 1;
	localparam int TC_IT0 = 0;
	localparam int PC_T0O_EN = 0;
	localparam int PC_T2O_EN = 1;
	localparam int PC_T2_RUN = 2;
	localparam int PC_T2_CT = 3;
	localparam int PC_T3_RUN = 4;
	localparam int IRQ_T0 = 0;
	localparam int IRQ_T1 = 1;
	localparam int IRQ_T2 = 2;
	localparam int IRQ_T3 = 3;
	localparam int IRQ_EXT0 = 4;
	localparam int IRQ_EXT1 = 5;
	localparam int IRQ_BITS = 6;
	localparam int ACK_EXT0 = 0;
	localparam int ACK_T0 = 1;
	localparam int ACK_EXT1 = 2;
	localparam int ACK_T1 = 3;
	////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
	localparam logic [7:0] MODE_SELECT_RESET = 8'h00;
	localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
	localparam logic [1:0] MODE_13BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;

	typedef struct packed {
		logic gate;
		logic ct;
		logic [1:0] mode;
	} tbc_mode_type;

	typedef struct packed {
		logic ovf;
		logic [7:0] tl;
		logic [7:0] th;
	} tbc_step_type;
endpackage

//--- hdl/tbc_timer_base.sv
/*
 timer0..timer3 with control register, overflow pins, interrupt status,
 and an AHB-Lite slave. assumes a single AHB master, word accesses only,
 and interrupt acknowledge pulses from the processor when it vectors.
*/
`timescale 1ns/1ps
module tbc_timer_base (
	input wire logic CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic T0_PIN,
	input wire logic T1_PIN,
	input wire logic T2_PIN,
	input wire logic INT0_N_PIN,
	input wire logic INT1_N_PIN,
	input wire logic SLOW_CRYSTAL_CLOCK,
	input wire logic [3:0] INT_ACK,
	output logic TIMER0_OVERFLOW_OUT,
	output logic TIMER2_OVERFLOW_OUT,
	output logic IRQ
);
	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} tbc_bus_type;

	tbc_bus_type bus_q, bus_d;
	logic [7:0] addr_q;
	logic [31:0] rdata_q;
	logic accept, wr_phase;
	logic [31:0] rd_mux;
	logic [7:0] wd;
	logic [7:0] timer_control_q, timer_control_d;
	logic [7:0] mode_q, pin_ctrl_q;
	logic [7:0] tl0_q, th0_q, tl1_q, th1_q, tl2_q, th2_q;
	logic [7:0] tl0_d, th0_d, tl1_d, th1_d;
	logic [15:0] t3_q;
	localparam int IRQ_BITS_W = tbc_pkg::IRQ_BITS;
	logic [IRQ_BITS_W-1:0] irq_st_q, irq_en_q, irq_ev;
	logic [3:0] tb_cnt_q;
	logic tick;
	logic [4:0] t0o_div_q;
	logic t0o_q, t2o_q, t0o_pin_q, t2o_pin_q;
	logic t0_fall, t1_fall, t2_fall, sxt_rise;
	logic int0_lvl, int1_lvl, int0_fall, int1_fall;
	tbc_pkg::tbc_mode_type m0, m1;
	tbc_pkg::tbc_step_type step0, step1;
	logic run0, run1, inc0, inc1, th_inc3, split0;
	logic [7:0] tl0_adv;
	logic ovf0_at, ev_ovf0, ev_ovf1, inc2, ev_ovf2, inc3, ev_ovf3;
	logic ev_ext0, ev_ext1;
	logic wr_timer_control, wr_tl0, wr_th0, wr_tl1, wr_th1, wr_mode, wr_pc;
	logic wr_tl2, wr_th2, wr_t3, wr_clr, wr_en;


	// one count step of a timer in modes 0..2; mode 3 is handled outside
	function automatic tbc_pkg::tbc_step_type tbc_step(input logic [1:0] m,
		input logic [7:0] tl, input logic [7:0] th);
		tbc_pkg::tbc_step_type r;
		logic [12:0] c13;
		logic [15:0] c16;
		r.ovf = 1'b0;
		r.tl = tl;
		r.th = th;
		c13 = {th, tl[4:0]} + 13'h0001;
		c16 = {th, tl} + 16'h0001;
		case (m)
			tbc_pkg::MODE_13BIT: begin
				r.ovf = ({th, tl[4:0]} == 13'h1FFF);
				r.th = c13[12:5];
				r.tl = {tl[7:5], c13[4:0]};
			end
			tbc_pkg::MODE_16BIT: begin
				r.ovf = ({th, tl} == 16'hFFFF);
				{r.th, r.tl} = c16;
			end
			tbc_pkg::MODE_RELOAD: begin
				r.ovf = (tl == 8'hFF);
				r.tl = r.ovf ? th : c16[7:0];
			end
			default: begin
				r.ovf = 1'b0;
			end
		endcase
		return r;
	endfunction

	function automatic logic wr_hit(input logic ph, input logic [7:0] a, input logic [7:0] r);
		return ph && (a == r);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pins
	tbc_pin_filter u_t0 (.CLK(CLK), .RST(RST), .PIN(T0_PIN), .LEVEL(), .FALL(t0_fall), .RISE());
	tbc_pin_filter u_t1 (.CLK(CLK), .RST(RST), .PIN(T1_PIN), .LEVEL(), .FALL(t1_fall), .RISE());
	tbc_pin_filter u_t2 (.CLK(CLK), .RST(RST), .PIN(T2_PIN), .LEVEL(), .FALL(t2_fall), .RISE());
	tbc_pin_filter u_i0 (.CLK(CLK), .RST(RST), .PIN(INT0_N_PIN), .LEVEL(int0_lvl),
		.FALL(int0_fall), .RISE());
	tbc_pin_filter u_i1 (.CLK(CLK), .RST(RST), .PIN(INT1_N_PIN), .LEVEL(int1_lvl),
		.FALL(int1_fall), .RISE());
	tbc_pin_filter u_sx (.CLK(CLK), .RST(RST), .PIN(SLOW_CRYSTAL_CLOCK), .LEVEL(), .FALL(),
		.RISE(sxt_rise));

	////////////////////////////////////////////////////////////////////////
	// bus slave: writes zero-wait, reads one wait state
	assign accept = HSEL && HTRANS[1] && HREADY;
	assign wr_phase = (bus_q == BUS_WRITE);
	assign wd = HWDATA[7:0];
	assign HREADYOUT = (bus_q != BUS_READ_WAIT);
	assign HRESP = 1'b0;
	assign HRDATA = rdata_q;

	always_comb begin
		bus_d = BUS_IDLE;
		if (accept) bus_d = HWRITE ? BUS_WRITE : BUS_READ_WAIT;
		else if (bus_q == BUS_READ_WAIT) bus_d = BUS_READ_DONE;
	end

	assign wr_timer_control = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_TIMER_CONTROL);
	assign wr_tl0 = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_TIMER0_LOW);
	assign wr_th0 = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_TIMER0_HIGH);
	assign wr_tl1 = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_TIMER1_LOW);
	assign wr_th1 = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_TIMER1_HIGH);
	assign wr_mode = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_MODE_SELECT);
	assign wr_pc = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_PIN_CTRL);
	assign wr_tl2 = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_TIMER2_LOW);
	assign wr_th2 = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_TIMER2_HIGH);
	assign wr_t3 = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_TIMER3_COUNT);
	assign wr_clr = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_IRQ_CLEAR);
	assign wr_en = wr_hit(wr_phase, addr_q, tbc_pkg::ADDR_IRQ_ENABLE);

	always_comb begin
		case (addr_q)
			tbc_pkg::ADDR_TIMER_CONTROL: rd_mux = {24'h000000, timer_control_q};
			tbc_pkg::ADDR_TIMER0_LOW: rd_mux = {24'h000000, tl0_q};
			tbc_pkg::ADDR_TIMER0_HIGH: rd_mux = {24'h000000, th0_q};
			tbc_pkg::ADDR_TIMER1_LOW: rd_mux = {24'h000000, tl1_q};
			tbc_pkg::ADDR_TIMER1_HIGH: rd_mux = {24'h000000, th1_q};
			tbc_pkg::ADDR_MODE_SELECT: rd_mux = {24'h000000, mode_q};
			tbc_pkg::ADDR_PIN_CTRL: rd_mux = {24'h000000, pin_ctrl_q};
			tbc_pkg::ADDR_TIMER2_LOW: rd_mux = {24'h000000, tl2_q};
			tbc_pkg::ADDR_TIMER2_HIGH: rd_mux = {24'h000000, th2_q};
			tbc_pkg::ADDR_TIMER3_COUNT: rd_mux = {16'h0000, t3_q};
			tbc_pkg::ADDR_IRQ_STATUS: rd_mux = {26'h0000000, irq_st_q};
			tbc_pkg::ADDR_IRQ_ENABLE: rd_mux = {26'h0000000, irq_en_q};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			bus_q <= BUS_IDLE;
			addr_q <= 8'h00;
			rdata_q <= 32'h00000000;
		end else begin
			bus_q <= bus_d;
			if (accept) addr_q <= HADDR[7:0];
			if (bus_q == BUS_READ_WAIT) rdata_q <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// time base and timer0/1
	assign tick = (tb_cnt_q == 4'(tbc_pkg::TIME_BASE_CYCLES - 1));
	assign m0 = mode_q[3:0];
	assign m1 = mode_q[7:4];
	assign split0 = (m0.mode == tbc_pkg::MODE_SPLIT);
	// gate lets the external interrupt pin hold the timer
	assign run0 = timer_control_q[tbc_pkg::TC_TR0] & (~m0.gate | int0_lvl);
	assign run1 = timer_control_q[tbc_pkg::TC_TR1] & (~m1.gate | int1_lvl);
	assign inc0 = run0 & (m0.ct ? t0_fall : tick);
	// timer1 halts in mode 3; with timer0 in mode 3 its run bit drives timer0 high byte
	assign inc1 = run1 & (m1.mode != tbc_pkg::MODE_SPLIT) & (m1.ct ? t1_fall : tick);
	assign th_inc3 = split0 & timer_control_q[tbc_pkg::TC_TR1] & tick;
	assign step0 = tbc_step(m0.mode, tl0_q, th0_q);
	assign step1 = tbc_step(m1.mode, tl1_q, th1_q);
	assign tl0_adv = split0 ? tl0_q + 8'h01 : step0.tl;
	assign ovf0_at = split0 ? (tl0_q == 8'hFF) : step0.ovf;
	assign ev_ovf0 = inc0 & ovf0_at;
	assign ev_ovf1 = (inc1 & step1.ovf) | (th_inc3 & (th0_q == 8'hFF));

	// software write to a count byte wins over the count step
	assign tl0_d = wr_tl0 ? wd : (inc0 ? tl0_adv : tl0_q);
	assign th0_d = wr_th0 ? wd : (split0 ? (th_inc3 ? th0_q + 8'h01 : th0_q) :
		(inc0 ? step0.th : th0_q));
	assign tl1_d = wr_tl1 ? wd : (inc1 ? step1.tl : tl1_q);
	assign th1_d = wr_th1 ? wd : (inc1 ? step1.th : th1_q);

	////////////////////////////////////////////////////////////////////////
	// control register: hardware set beats software or vector clear
	assign ev_ext0 = timer_control_q[tbc_pkg::TC_IT0] ? int0_fall : ~int0_lvl;
	assign ev_ext1 = timer_control_q[tbc_pkg::TC_IT1] ? int1_fall : ~int1_lvl;

	always_comb begin
		timer_control_d = wr_timer_control ? wd : timer_control_q;
		if (!wr_timer_control) begin
			timer_control_d[tbc_pkg::TC_TF1] = timer_control_q[tbc_pkg::TC_TF1]
				& ~INT_ACK[tbc_pkg::ACK_T1];
			timer_control_d[tbc_pkg::TC_TF0] = timer_control_q[tbc_pkg::TC_TF0]
				& ~INT_ACK[tbc_pkg::ACK_T0];
			timer_control_d[tbc_pkg::TC_IE1] = timer_control_q[tbc_pkg::TC_IE1]
				& ~INT_ACK[tbc_pkg::ACK_EXT1];
			timer_control_d[tbc_pkg::TC_IE0] = timer_control_q[tbc_pkg::TC_IE0]
				& ~INT_ACK[tbc_pkg::ACK_EXT0];
		end
		if (ev_ovf1) timer_control_d[tbc_pkg::TC_TF1] = 1'b1;
		if (ev_ovf0) timer_control_d[tbc_pkg::TC_TF0] = 1'b1;
		// level mode: flag follows the pin, edge mode: sticky
		if (!timer_control_q[tbc_pkg::TC_IT1]) timer_control_d[tbc_pkg::TC_IE1] = ~int1_lvl;
		else if (ev_ext1) timer_control_d[tbc_pkg::TC_IE1] = 1'b1;
		if (!timer_control_q[tbc_pkg::TC_IT0]) timer_control_d[tbc_pkg::TC_IE0] = ~int0_lvl;
		else if (ev_ext0) timer_control_d[tbc_pkg::TC_IE0] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// timer2, timer3 real-time counter, events
	assign inc2 = pin_ctrl_q[tbc_pkg::PC_T2_RUN] & (pin_ctrl_q[tbc_pkg::PC_T2_CT] ? t2_fall : tick);
	assign ev_ovf2 = inc2 & ({th2_q, tl2_q} == 16'hFFFF);
	assign inc3 = pin_ctrl_q[tbc_pkg::PC_T3_RUN] & sxt_rise;
	assign ev_ovf3 = inc3 & (t3_q == 16'hFFFF);
	assign irq_ev = {ev_ext1, ev_ext0, ev_ovf3, ev_ovf2, ev_ovf1, ev_ovf0};
	assign IRQ = |(irq_st_q & irq_en_q);
	assign TIMER0_OVERFLOW_OUT = t0o_pin_q;
	assign TIMER2_OVERFLOW_OUT = t2o_pin_q;

	always_ff @(posedge CLK) begin
		if (RST) begin
			tb_cnt_q <= 4'h0;
			timer_control_q <= tbc_pkg::TIMER_CONTROL_RESET;
			mode_q <= tbc_pkg::MODE_SELECT_RESET;
			pin_ctrl_q <= tbc_pkg::PIN_CTRL_RESET;
			{tl0_q, th0_q, tl1_q, th1_q, tl2_q, th2_q} <= 48'h000000000000;
			t3_q <= 16'h0000;
			irq_st_q <= 6'h00;
			irq_en_q <= 6'h00;
			{t0o_div_q, t0o_q, t2o_q, t0o_pin_q, t2o_pin_q} <= 9'h000;
		end else begin
			tb_cnt_q <= tick ? 4'h0 : tb_cnt_q + 4'h1;
			timer_control_q <= timer_control_d;
			{tl0_q, th0_q, tl1_q, th1_q} <= {tl0_d, th0_d, tl1_d, th1_d};
			if (wr_mode) mode_q <= wd;
			if (wr_pc) pin_ctrl_q <= {3'h0, wd[4:0]};
			if (wr_tl2) tl2_q <= wd;
			else if (inc2) tl2_q <= tl2_q + 8'h01;
			if (wr_th2) th2_q <= wd;
			else if (inc2 && tl2_q == 8'hFF) th2_q <= th2_q + 8'h01;
			if (wr_t3) t3_q <= HWDATA[15:0];
			else if (inc3) t3_q <= t3_q + 16'h0001;
			irq_st_q <= irq_ev | (irq_st_q & ~(wr_clr ? HWDATA[5:0] : 6'h00));
			if (wr_en) irq_en_q <= HWDATA[5:0];
			if (ev_ovf0) t0o_div_q <= t0o_div_q + 5'h01;
			// 32 overflows per half period gives a divide by 64
			if (ev_ovf0 && t0o_div_q == 5'(tbc_pkg::T0O_HALF - 1)) t0o_q <= ~t0o_q;
			if (ev_ovf2) t2o_q <= ~t2o_q;
			t0o_pin_q <= pin_ctrl_q[tbc_pkg::PC_T0O_EN] & t0o_q;
			t2o_pin_q <= pin_ctrl_q[tbc_pkg::PC_T2O_EN] & t2o_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_read_taken;
		accept && !HWRITE;
	endsequence
	sequence s_one_wait;
		!HREADYOUT ##1 HREADYOUT;
	endsequence

	a_read_wait_state: assert property (s_read_taken |=> s_one_wait)
		else $error("read did not take exactly one wait state");
	a_tick_period: assert property (tick |=> !tick ##1 tick)
		else $error("time base tick not every two clocks");
	a_tf1_on_ovf: assert property (ev_ovf1 |=> timer_control_q[7])
		else $error("timer1 overflow flag not set on overflow");
	a_tf0_vector_clear: assert property (INT_ACK[1] && !ev_ovf0 && !wr_timer_control
		|=> !timer_control_q[5])
		else $error("timer0 flag not cleared by vector");
	a_t2o_toggle: assert property (ev_ovf2 |=> t2o_q != $past(t2o_q))
		else $error("timer2 output did not toggle on overflow");
	a_t0o_divide: assert property ($changed(t0o_q) |-> $past(ev_ovf0 && t0o_div_q == 5'h1F))
		else $error("timer0 output changed off the divide point");
	a_ctrl_reset: assert property ($fell(RST) |-> timer_control_q == 8'h00)
		else $error("control register not zero after reset");
	a_t0_mode1_step: assert property (inc0 && m0.mode == 2'h1 && !wr_tl0 && !wr_th0
		|=> {th0_q, tl0_q} == $past({th0_q, tl0_q}) + 16'h0001)
		else $error("timer0 16-bit step wrong");
	a_tl0_write: assert property (wr_tl0 |=> tl0_q == $past(HWDATA[7:0]))
		else $error("timer0 low byte write lost");
	a_rtc_step: assert property (inc3 && !wr_t3 |=> t3_q == $past(t3_q) + 16'h0001)
		else $error("timer3 did not count slow crystal edge");
endmodule // tbc_timer_base

//--- verification/tb_top.sv
/*
 self-checking bench for the timer block, with a register model.
 assumes one AHB-Lite slave whose HREADYOUT is the bus ready.
*/
`timescale 1ns/1ps
module tb_top;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = 32'h0;
	logic [2:0] HSIZE = 3'h2;
	logic INT0_N_PIN = 1'b1;
	logic SLOW_CRYSTAL_CLOCK = 1'b0;
	logic [3:0] INT_ACK = 4'h0;
	logic [31:0] HRDATA;
	logic HREADYOUT, HRESP, T0_PIN, T1_PIN, T2_PIN, T0O, T2O, IRQ;
	logic [31:0] rd;
	int fail_count = 0;
	int n_checks = 0;
	int seed = 5;
	int n, cnt;
	logic [31:0] mdl [0:255];
	always #25 CLK = ~CLK;
	tbc_pulse_source src (.CLK(CLK), .T0_PIN(T0_PIN), .T1_PIN(T1_PIN), .T2_PIN(T2_PIN));
	tbc_timer_base uut (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .T0_PIN(T0_PIN),
		.T1_PIN(T1_PIN), .T2_PIN(T2_PIN), .INT0_N_PIN(INT0_N_PIN), .INT1_N_PIN(1'b1),
		.SLOW_CRYSTAL_CLOCK(SLOW_CRYSTAL_CLOCK), .INT_ACK(INT_ACK),
		.TIMER0_OVERFLOW_OUT(T0O), .TIMER2_OVERFLOW_OUT(T2O), .IRQ(IRQ));
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (fail_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// rate checks allow one tick of slack: tick phase at start is unknown
	function automatic logic [31:0] near(input logic [31:0] s, input int nom);
		return (^s !== 1'bx && s + 1 >= nom && s <= nom + 1) ? s : nom;
	endfunction
	// watched output: 0 irq, 1 timer0 pin, 2 timer2 pin
	function automatic logic pick(input int sel);
		if (sel == 0) return IRQ;
		if (sel == 1) return T0O;
		return T2O;
	endfunction
	// bounded wait until the watched output differs from its value at entry
	task automatic wait_chg(input int sel, input int lim, output int c);
		logic v;
		v = pick(sel);
		c = 0;
		do begin
			@(posedge CLK);
			c++;
			if (c > lim) begin
				fail_count++;
				finish_test();
			end
		end while (pick(sel) === v);
	endtask
	////////////////////////////////////////////////////////////////////////
	// request and data held until an edge that samples ready high
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		HSIZE <= 3'h2;
		bus_wait_hi();
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		bus_wait_hi();
		rd = HRDATA;
	endtask
	// at least one edge, then until ready is sampled high
	task automatic bus_wait_hi();
		int c;
		c = 0;
		do begin
			@(posedge CLK);
			c++;
			if (c > 20) begin
				fail_count++;
				finish_test();
			end
		end while (HREADYOUT !== 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
		mdl[a] = d & 32'hFF;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		rdc(8'h88, tbc_pkg::TIMER_CONTROL_RESET);
		rdc(8'hB0, 32'h0);
		rdc(8'hFC, 32'h0);
		check({31'h0, HRESP}, 32'h0);
		// byte pairs of timer0 and timer1, back to back
		for (int i = 0; i < 4; i++) wr(8'h8C + 8'(4 * i), 32'($random(seed)));
		for (int i = 0; i < 4; i++) rdc(8'h8C + 8'(4 * i), mdl[8'h8C + 4 * i]);
		// flags and trigger types written by software
		wr(8'h88, 32'hA5);
		rdc(8'h88, mdl[8'h88]);
		// vectoring into timer0 service clears its flag only
		INT_ACK <= 4'h2;
		@(posedge CLK);
		INT_ACK <= 4'h0;
		rdc(8'h88, 32'h85);
		wr(8'h88, 32'h05);
		@(posedge CLK);
		INT0_N_PIN <= 1'b0;
		repeat (4) @(posedge CLK);
		INT0_N_PIN <= 1'b1;
		repeat (6) @(posedge CLK);
		rdc(8'h88, 32'h07);
		// timer mode rate, 16-bit, run window of 200 clocks
		wr(8'h9C, {30'h0, tbc_pkg::MODE_16BIT});
		wr(8'h8C, 32'h0);
		wr(8'h90, 32'h0);
		wr(8'h88, 32'h10);
		repeat (197) @(posedge CLK);
		wr(8'h88, 32'h0);
		ahb(1'b0, 8'h8C, 32'h0);
		check(rd, near(rd, 200 / tbc_pkg::TIME_BASE_CYCLES));
		// counter mode on timer1: whole pulses count, a glitch does not
		wr(8'h9C, 32'h50);
		wr(8'h94, 32'h0);
		wr(8'h98, 32'h0);
		wr(8'h88, 32'h40);
		n = 3 + ($random(seed) & 7);
		cnt = n;
		src.send(1, n, 3);
		src.send(1, 1, 1);
		repeat (10) @(posedge CLK);
		rdc(8'h94, 32'(cnt));
		// stop timer1 before reloading it, else it overflows early
		wr(8'h88, 32'h0);
		// timer1 reload mode overflow, interrupt, ack, clear, mask
		wr(8'h9C, {26'h0, tbc_pkg::MODE_RELOAD, 4'h0});
		wr(8'h98, 32'h0);
		wr(8'h94, 32'hFE);
		wr(8'hB8, 32'h02);
		wr(8'h88, 32'h40);
		wait_chg(0, 40, n);
		INT_ACK <= 4'h8;
		@(posedge CLK);
		INT_ACK <= 4'h0;
		repeat (2) @(posedge CLK);
		rdc(8'h88, 32'h40);
		check({31'h0, IRQ}, 32'h1);
		wr(8'hB4, 32'h02);
		@(posedge CLK);
		check({31'h0, IRQ}, 32'h0);
		wr(8'hB8, 32'h0);
		repeat (520) @(posedge CLK);
		ahb(1'b0, 8'hB0, 32'h0);
		check({31'h0, rd[1]}, 32'h1);
		check({31'h0, IRQ}, 32'h0);
		wr(8'h88, 32'h0);
		// timer0 reload from 0xFF overflows every tick
		wr(8'h9C, {30'h0, tbc_pkg::MODE_RELOAD});
		wr(8'h90, 32'hFF);
		wr(8'h8C, 32'hFF);
		wr(8'hA0, 32'h01);
		wr(8'h88, 32'h10);
		wait_chg(1, 200, n);
		wait_chg(1, 200, n);
		check(32'(n), 32'(tbc_pkg::T0O_HALF * tbc_pkg::TIME_BASE_CYCLES));
		wr(8'h88, 32'h0);
		// timer2 near the top, one overflow toggles its pin
		wr(8'hA4, 32'hFF);
		wr(8'hA8, 32'hFF);
		wr(8'hA0, 32'h06);
		wait_chg(2, 40, n);
		check({31'h0, T2O}, 32'h1);
		ahb(1'b0, 8'hB0, 32'h0);
		check({31'h0, rd[2]}, 32'h1);
		// timer3 counts rising edges of the slow crystal
		wr(8'hA0, 32'h10);
		repeat (5) begin
			repeat (6) @(posedge CLK);
			SLOW_CRYSTAL_CLOCK <= 1'b1;
			repeat (6) @(posedge CLK);
			SLOW_CRYSTAL_CLOCK <= 1'b0;
		end
		repeat (8) @(posedge CLK);
		rdc(8'hAC, 32'h5);
		bus_wait_hi();
		finish_test();
	end
endmodule // tb_top

//--- verification/tbc_pulse_source.sv
/*
 pulse source for the three timer count pins.
 assumes idle-high pins; the bench calls send from its main thread.
*/
`timescale 1ns/1ps
module tbc_pulse_source (
	input wire logic CLK,
	output logic T0_PIN,
	output logic T1_PIN,
	output logic T2_PIN
);
	logic [2:0] pins_q = 3'h7;
	assign T0_PIN = pins_q[0];
	assign T1_PIN = pins_q[1];
	assign T2_PIN = pins_q[2];
	////////////////////////////////////////////////////////////////////////
	// each level held wid clocks; wid of 1 is a deliberate glitch
	task automatic send(input int ch, input int n, input int wid);
		for (int i = 0; i < n; i++) begin
			@(posedge CLK);
			pins_q[ch] <= 1'b0;
			repeat (wid) @(posedge CLK);
			pins_q[ch] <= 1'b1;
			repeat (wid - 1) @(posedge CLK);
		end
	endtask
endmodule // tbc_pulse_source
